// ==== logic/rsg_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef RSG_REGS_SVH
`define RSG_REGS_SVH

// Register addresses on the register port
`define RSG_CAUSE_ADDR 8'hEF
`define RSG_STORE_ADDR 8'h8F
`define RSG_KEY_ADDR 8'hB7

// Reset cause and enable register fields
`define RSG_PIN_BIT 0
`define RSG_POR_BIT 1
`define RSG_LCK_BIT 2
`define RSG_WDT_BIT 3
`define RSG_SOFT_BIT 4
`define RSG_CMP_BIT 5
`define RSG_FERR_BIT 6
`define RSG_UNUSED_BIT 7
`define RSG_POR_FLAGS 7'h02

// Program store control fields
`define RSG_WE_BIT 0
`define RSG_EE_BIT 1

// Unlock keys
`define RSG_KEY1 8'hA5
`define RSG_KEY2 8'hF1

// Flash geometry
`define RSG_PAGE_BYTES 512
`define RSG_ERASE_FILL 8'hFF
`define RSG_ADDR8_MAX 16'h00FF
`define RSG_LOCK_ADDR 16'h1DFF

// Timing
`define RSG_WDT_DIV 12
`define RSG_WDT_LIMIT 256
`define RSG_CLK_NS 4
`define RSG_FL_WRITE_NS 40000
`define RSG_FL_ERASE_NS 20000000
`define RSG_FL_WRITE_CYC ((`RSG_FL_WRITE_NS + `RSG_CLK_NS - 1) / `RSG_CLK_NS)
`define RSG_FL_ERASE_CYC ((`RSG_FL_ERASE_NS + `RSG_CLK_NS - 1) / `RSG_CLK_NS)
`define RSG_RST_HOLD_CYC 16

`endif

// ==== logic/rsg_pkg.sv ====
// Types shared by the reset and flash guard block
package rsg_pkg;
    typedef enum logic [1:0] {
        KEY_LOCKED,
        KEY_HALF,
        KEY_OPEN,
        KEY_DEAD
    } rsg_key_t;

    typedef enum logic {
        SEQ_RUN,
        SEQ_HOLD
    } rsg_seq_t;
endpackage

// ==== logic/rsg_watchdog.sv ====
// Watchdog counter on the system clock, stepped once every DIV clock cycles
`timescale 1ns/100ps
`default_nettype none
module rsg_watchdog #(
    parameter int DIV = 12,
    parameter int LIMIT = 256
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Control
    input wire logic clr,
    input wire logic kick,
    input wire logic dis,
    // Timeout
    output logic expire
);
    logic en_q, en_d;
    logic [3:0] div_q, div_d;
    logic [15:0] cnt_q, cnt_d;
    logic exp_q, exp_d;

    always_comb begin
        en_d = en_q;
        div_d = div_q;
        cnt_d = cnt_q;
        exp_d = 1'b0;
        if (clr) begin
            en_d = 1'b1;
            div_d = 4'h0;
            cnt_d = 16'h0000;
        end else begin
            if (dis) begin
                en_d = 1'b0;
            end
            if (kick) begin
                cnt_d = 16'h0000;
            end else if (en_q) begin
                if (div_q == 4'(DIV - 1)) begin
                    div_d = 4'h0;
                    if (cnt_q == 16'(LIMIT - 1)) begin
                        cnt_d = 16'h0000;
                        exp_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 16'h0001;
                    end
                end else begin
                    div_d = div_q + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            en_q <= 1'b1;
            div_q <= 4'h0;
            cnt_q <= 16'h0000;
            exp_q <= 1'b0;
        end else begin
            en_q <= en_d;
            div_q <= div_d;
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign expire = exp_q;
endmodule // rsg_watchdog
`default_nettype wire

// ==== logic/rsg_op_timer.sv ====
// Down counter that times one flash operation
`timescale 1ns/100ps
`default_nettype none
module rsg_op_timer #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Start with a cycle count
    input wire logic start,
    input wire logic [W-1:0] load,
    // Status
    output logic busy
);
    logic [W-1:0] cnt_q, cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = load;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy = (cnt_q != '0);
endmodule // rsg_op_timer
`default_nettype wire

// ==== logic/rsg_reset_guard.sv ====
// Reset source sequencer and flash program-store guard
`timescale 1ns/100ps
`default_nettype none
`include "rsg_regs.svh"

module rsg_reset_guard #(
    parameter int LOCK_ADDR = `RSG_LOCK_ADDR,
    parameter int PAGE_BYTES = `RSG_PAGE_BYTES,
    parameter int WRITE_CYCLES = `RSG_FL_WRITE_CYC,
    parameter int ERASE_CYCLES = `RSG_FL_ERASE_CYC,
    parameter int WDT_LIMIT = `RSG_WDT_LIMIT
) (
    // Clock and power-on reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic sfr_re,
    output logic [7:0] sfr_rdata,
    // Data-space writes from the core
    input wire logic xw_valid,
    input wire logic [15:0] xw_addr,
    input wire logic [7:0] xw_data,
    input wire logic xw_short,
    // Code-space reads and branch fetches
    input wire logic cr_valid,
    input wire logic [15:0] cr_addr,
    input wire logic br_valid,
    input wire logic [15:0] br_addr,
    // Security and supply status
    input wire logic sec_deny,
    input wire logic supply_on,
    // Watchdog servicing
    input wire logic wdt_kick,
    input wire logic wdt_disable,
    // Asynchronous reset sources
    input wire logic rst_pin_n_in,
    input wire logic cmp_out_n,
    input wire logic lost_clk,
    input wire logic supply_low,
    // External reset pin drive
    output logic rst_pin_o,
    output logic rst_pin_oe,
    // Flash array
    input wire logic [7:0] fl_cur_data,
    output logic fl_prog,
    output logic fl_erase,
    output logic [15:0] fl_addr,
    output logic [7:0] fl_wdata,
    // System
    output logic cpu_stall,
    output logic sys_rst_n
);
    // Synchronisers: {supply_low, lost_clk, cmp_out_n, pin_n}
    logic [3:0] sync1_q, sync2_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 4'h3;
            sync2_q <= 4'h3;
        end else begin
            sync1_q <= {supply_low, lost_clk, cmp_out_n, rst_pin_n_in};
            sync2_q <= sync1_q;
        end
    end
    logic pin_low_s, cmp_low_s, lost_s, supply_low_s;
    assign pin_low_s = ~sync2_q[0];
    assign cmp_low_s = ~sync2_q[1];
    assign lost_s = sync2_q[2];
    assign supply_low_s = sync2_q[3];

    // Register decode
    logic wr_rst, wr_ps, wr_key;
    assign wr_rst = sfr_we && (sfr_addr == `RSG_CAUSE_ADDR);
    assign wr_ps = sfr_we && (sfr_addr == `RSG_STORE_ADDR);
    assign wr_key = sfr_we && (sfr_addr == `RSG_KEY_ADDR);

    // Reset sequencer state
    rsg_pkg::rsg_seq_t seq_q, seq_d;
    logic [6:0] cause_q, cause_d, flags_q, flags_d;
    logic [7:0] hold_q, hold_d;
    logic cmp_en_q, cmp_en_d, lost_en_q, lost_en_d, sup_sel_q, sup_sel_d;
    logic sys_rst_n_q, sys_rst_n_d, pin_oe_q, pin_oe_d;
    logic in_hold, wdt_exp, ferr;
    logic [6:0] src;

    assign in_hold = (seq_q == rsg_pkg::SEQ_HOLD);

    rsg_watchdog #(
        .DIV(`RSG_WDT_DIV),
        .LIMIT(WDT_LIMIT)
    ) u_wdt (
        .core_clk(core_clk),
        .rstn(rstn),
        .clr(in_hold),
        .kick(wdt_kick),
        .dis(wdt_disable),
        .expire(wdt_exp)
    );

    always_comb begin
        src = 7'h00;
        src[`RSG_PIN_BIT] = pin_low_s;
        src[`RSG_POR_BIT] = sup_sel_q && supply_low_s;
        src[`RSG_LCK_BIT] = lost_en_q && lost_s;
        src[`RSG_WDT_BIT] = wdt_exp;
        src[`RSG_SOFT_BIT] = wr_rst && sfr_wdata[`RSG_SOFT_BIT];
        src[`RSG_CMP_BIT] = cmp_en_q && cmp_low_s;
        src[`RSG_FERR_BIT] = ferr;
    end

    always_comb begin
        seq_d = seq_q;
        cause_d = cause_q;
        flags_d = flags_q;
        hold_d = hold_q;
        cmp_en_d = cmp_en_q;
        lost_en_d = lost_en_q;
        sup_sel_d = sup_sel_q;
        case (seq_q)
            rsg_pkg::SEQ_RUN: begin
                if (wr_rst) begin
                    cmp_en_d = sfr_wdata[`RSG_CMP_BIT];
                    lost_en_d = sfr_wdata[`RSG_LCK_BIT];
                    sup_sel_d = sfr_wdata[`RSG_POR_BIT];
                end
                if (src != 7'h00) begin
                    seq_d = rsg_pkg::SEQ_HOLD;
                    cause_d = src;
                    hold_d = 8'(`RSG_RST_HOLD_CYC);
                    cmp_en_d = 1'b0;
                    lost_en_d = 1'b0;
                end
            end
            rsg_pkg::SEQ_HOLD: begin
                if (hold_q != 8'h00) begin
                    hold_d = hold_q - 8'h01;
                end else if (!pin_low_s) begin
                    seq_d = rsg_pkg::SEQ_RUN;
                    flags_d = cause_q;
                end
            end
            default: begin
                seq_d = rsg_pkg::SEQ_RUN;
            end
        endcase
        sys_rst_n_d = (seq_d == rsg_pkg::SEQ_RUN);
        // Only a supply reset pulls the pin; other causes leave it free
        pin_oe_d = (seq_d == rsg_pkg::SEQ_HOLD) &&
            cause_d[`RSG_POR_BIT];
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            seq_q <= rsg_pkg::SEQ_RUN;
            cause_q <= 7'h00;
            flags_q <= `RSG_POR_FLAGS;
            hold_q <= 8'h00;
            cmp_en_q <= 1'b0;
            lost_en_q <= 1'b0;
            sup_sel_q <= 1'b1;
            sys_rst_n_q <= 1'b1;
            pin_oe_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            cause_q <= cause_d;
            flags_q <= flags_d;
            hold_q <= hold_d;
            cmp_en_q <= cmp_en_d;
            lost_en_q <= lost_en_d;
            sup_sel_q <= sup_sel_d;
            sys_rst_n_q <= sys_rst_n_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    // Flash guard state
    rsg_pkg::rsg_key_t key_q, key_d;
    logic st_we_q, st_we_d, st_ee_q, st_ee_d;
    logic prog_q, prog_d, erase_q, erase_d;
    logic [15:0] faddr_q, faddr_d;
    logic [7:0] fdata_q, fdata_d;
    logic [31:0] op_load;
    logic op_start, busy, xw_try, short_bad;

    rsg_op_timer #(
        .W(32)
    ) u_timer (
        .core_clk(core_clk),
        .rstn(rstn),
        .start(op_start),
        .load(op_load),
        .busy(busy)
    );

    assign short_bad = xw_short && (xw_addr > `RSG_ADDR8_MAX);
    assign xw_try = xw_valid && st_we_q && !busy && !in_hold;

    always_comb begin
        key_d = key_q;
        st_we_d = st_we_q;
        st_ee_d = st_ee_q;
        prog_d = 1'b0;
        erase_d = 1'b0;
        faddr_d = faddr_q;
        fdata_d = fdata_q;
        op_start = 1'b0;
        op_load = 32'h0000_0000;
        ferr = 1'b0;
        if (in_hold) begin
            key_d = rsg_pkg::KEY_LOCKED;
            st_we_d = 1'b0;
            st_ee_d = 1'b0;
        end else begin
            if (cr_valid && (cr_addr > 16'(LOCK_ADDR))) begin
                ferr = 1'b1;
            end
            if (br_valid && (br_addr > 16'(LOCK_ADDR))) begin
                ferr = 1'b1;
            end
            if ((cr_valid || br_valid) && sec_deny) begin
                ferr = 1'b1;
            end
            if (wr_ps) begin
                st_we_d = sfr_wdata[`RSG_WE_BIT];
                st_ee_d = sfr_wdata[`RSG_EE_BIT];
            end
            if (wr_key) begin
                case (key_q)
                    rsg_pkg::KEY_LOCKED: begin
                        key_d = (sfr_wdata == `RSG_KEY1) ?
                            rsg_pkg::KEY_HALF : rsg_pkg::KEY_DEAD;
                    end
                    rsg_pkg::KEY_HALF: begin
                        key_d = (sfr_wdata == `RSG_KEY2) ?
                            rsg_pkg::KEY_OPEN : rsg_pkg::KEY_DEAD;
                    end
                    default: begin
                        key_d = rsg_pkg::KEY_DEAD;
                    end
                endcase
            end
            if (xw_try && !short_bad) begin
                if (xw_addr > 16'(LOCK_ADDR)) begin
                    ferr = 1'b1;
                end else if (!supply_on) begin
                    ferr = 1'b1;
                end else if (sec_deny) begin
                    ferr = 1'b1;
                end else if (key_q == rsg_pkg::KEY_OPEN) begin
                    key_d = rsg_pkg::KEY_LOCKED;
                    op_start = 1'b1;
                    if (st_ee_q) begin
                        // Page base of the addressed byte
                        faddr_d = xw_addr & ~16'(PAGE_BYTES - 1);
                        fdata_d = `RSG_ERASE_FILL;
                        erase_d = 1'b1;
                        op_load = 32'(ERASE_CYCLES);
                    end else begin
                        faddr_d = xw_addr;
                        fdata_d = fl_cur_data & xw_data;
                        prog_d = 1'b1;
                        op_load = 32'(WRITE_CYCLES);
                    end
                end else begin
                    key_d = rsg_pkg::KEY_DEAD;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            key_q <= rsg_pkg::KEY_LOCKED;
            st_we_q <= 1'b0;
            st_ee_q <= 1'b0;
            prog_q <= 1'b0;
            erase_q <= 1'b0;
            faddr_q <= 16'h0000;
            fdata_q <= 8'h00;
        end else begin
            key_q <= key_d;
            st_we_q <= st_we_d;
            st_ee_q <= st_ee_d;
            prog_q <= prog_d;
            erase_q <= erase_d;
            faddr_q <= faddr_d;
            fdata_q <= fdata_d;
        end
    end

    // Register read port, one cycle after the strobe
    logic [7:0] rdata_q, rdata_d;
    always_comb begin
        rdata_d = rdata_q;
        if (sfr_re) begin
            case (sfr_addr)
                `RSG_CAUSE_ADDR: rdata_d = {1'b1, flags_q};
                `RSG_STORE_ADDR: rdata_d = {6'h00, st_ee_q, st_we_q};
                `RSG_KEY_ADDR: rdata_d = {6'h00, key_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe = pin_oe_q;
    assign fl_prog = prog_q;
    assign fl_erase = erase_q;
    assign fl_addr = faddr_q;
    assign fl_wdata = fdata_q;
    assign cpu_stall = busy;
    assign sys_rst_n = sys_rst_n_q;
endmodule // rsg_reset_guard
`default_nettype wire

// ==== sim/rsg_reset_guard_properties.sv ====
// Port checks for the reset and flash guard
`timescale 1ns/100ps
`default_nettype none
`include "rsg_regs.svh"
module rsg_reset_guard_properties #(
    parameter int LOCK_ADDR = 16'h1DFF,
    parameter int WRITE_CYCLES = 20,
    parameter int ERASE_CYCLES = 40
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Requests
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic [15:0] xw_addr,
    input wire logic [7:0] xw_data,
    input wire logic xw_short,
    input wire logic cr_valid,
    input wire logic [15:0] cr_addr,
    input wire logic br_valid,
    input wire logic [15:0] br_addr,
    input wire logic sec_deny,
    input wire logic supply_low,
    input wire logic [7:0] fl_cur_data,
    // Responses
    input wire logic rst_pin_oe,
    input wire logic fl_prog,
    input wire logic fl_erase,
    input wire logic [15:0] fl_addr,
    input wire logic [7:0] fl_wdata,
    input wire logic cpu_stall,
    input wire logic sys_rst_n
);
    logic [31:0] stall_q;
    logic [31:0] stall_d;
    // Length of the current stall run
    always_comb begin
        stall_d = cpu_stall ? stall_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stall_q <= 32'h0;
        end else begin
            stall_q <= stall_d;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    chk_soft_force: assert property (
        sfr_we && sfr_addr == `RSG_CAUSE_ADDR && sfr_wdata[4] && sys_rst_n
        |=> !sys_rst_n) else $error("soft reset missing");
    chk_code_read: assert property (
        cr_valid && (cr_addr > LOCK_ADDR || sec_deny) && sys_rst_n
        |=> !sys_rst_n) else $error("code read fault missed");
    chk_branch_fetch: assert property (
        br_valid && br_addr > LOCK_ADDR && sys_rst_n |=> !sys_rst_n)
        else $error("branch fault missed");
    chk_pin_quiet: assert property (
        $fell(sys_rst_n) && !supply_low |-> !rst_pin_oe [*4])
        else $error("pin driven");
    chk_stall_len: assert property (
        $fell(cpu_stall) |->
        stall_q == WRITE_CYCLES || stall_q == ERASE_CYCLES)
        else $error("stall length wrong");
    chk_prog_data: assert property (
        fl_prog |-> fl_wdata == ($past(fl_cur_data) & $past(xw_data))
        && fl_addr == $past(xw_addr)) else $error("program byte wrong");
    chk_erase_page: assert property (
        fl_erase |-> fl_addr == ($past(xw_addr) & 16'hFE00))
        else $error("erase page wrong");
    chk_short_reach: assert property (
        (fl_prog || fl_erase) && $past(xw_short)
        |-> $past(xw_addr) <= `RSG_ADDR8_MAX) else $error("short write");
    cover property (fl_prog);
    cover property (fl_erase);
    cover property ($fell(sys_rst_n));
endmodule // rsg_reset_guard_properties
bind rsg_reset_guard rsg_reset_guard_properties #(
    .LOCK_ADDR(LOCK_ADDR), .WRITE_CYCLES(WRITE_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
) rsg_reset_guard_properties_inst (
    .core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .xw_addr(xw_addr),
    .xw_data(xw_data), .xw_short(xw_short), .cr_valid(cr_valid),
    .cr_addr(cr_addr), .br_valid(br_valid), .br_addr(br_addr),
    .sec_deny(sec_deny), .supply_low(supply_low),
    .fl_cur_data(fl_cur_data), .rst_pin_oe(rst_pin_oe),
    .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .cpu_stall(cpu_stall), .sys_rst_n(sys_rst_n)
);
`default_nettype wire

// ==== sim/rsg_flash_model.sv ====
// Flash array model behind the guard
`timescale 1ns/100ps
`default_nettype none
module rsg_flash_model (
    // Clock
    input wire logic core_clk,
    // Strobes from the guard
    input wire logic fl_prog,
    input wire logic fl_erase,
    input wire logic [15:0] fl_addr,
    input wire logic [7:0] fl_wdata,
    // Byte under the write address
    input wire logic [15:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:8191];
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    assign rd_data = mem[rd_addr[12:0]];
    // Stores exactly what it is handed, so a missing AND shows up
    always @(posedge core_clk) begin
        if (fl_prog) begin
            mem[fl_addr[12:0]] <= fl_wdata;
        end
        if (fl_erase) begin
            for (int i = 0; i < 512; i++) begin
                mem[{fl_addr[12:9], 9'h000} + 13'(i)] <= 8'hFF;
            end
        end
    end
endmodule // rsg_flash_model
`default_nettype wire

// ==== sim/tb_rsg_reset_guard.sv ====
// Self-checking bench for the reset and flash guard
`timescale 1ns/100ps
`default_nettype none
`include "rsg_regs.svh"
module tb_rsg_reset_guard;
    typedef struct packed {
        logic [15:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } rsg_row_t;
    localparam logic [7:0] RS = `RSG_CAUSE_ADDR;
    localparam logic [7:0] FK = `RSG_KEY_ADDR;
    localparam logic [7:0] PS = `RSG_STORE_ADDR;
    logic core_clk = '0, rstn = '0, sfr_we = '0, sfr_re = '0;
    logic [7:0] sfr_addr = '0, sfr_wdata = '0, xw_data = '0;
    logic xw_valid = '0, xw_short = '0, cr_valid = '0, br_valid = '0;
    logic [15:0] xw_addr = '0, cr_addr = '0, br_addr = '0, fl_addr;
    logic sec_deny = '0, supply_on = '1, wdt_kick = '0, kick_on = '1;
    logic rst_pin_n_in = '1, cmp_out_n = '1, lost_clk = '0;
    logic [7:0] sfr_rdata, fl_cur_data, fl_wdata;
    logic fl_prog, fl_erase, cpu_stall, sys_rst_n;
    logic supply_low = '0, wdt_disable = '0, rst_pin_o, rst_pin_oe;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    rsg_row_t rows [5] = '{'{16'h0100, 8'h0F, 8'h0F},
        '{16'h0100, 8'hF3, 8'h03}, '{16'h0101, 8'h5A, 8'h5A},
        '{16'h01FF, 8'h00, 8'h00}, '{16'h0200, 8'h00, 8'h00}};
    rsg_reset_guard #(
        .WRITE_CYCLES(20), .ERASE_CYCLES(40), .WDT_LIMIT(4)
    ) rsg_reset_guard_inst (
        .core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re),
        .sfr_rdata(sfr_rdata), .xw_valid(xw_valid), .xw_addr(xw_addr),
        .xw_data(xw_data), .xw_short(xw_short), .cr_valid(cr_valid),
        .cr_addr(cr_addr), .br_valid(br_valid), .br_addr(br_addr),
        .sec_deny(sec_deny), .supply_on(supply_on), .wdt_kick(wdt_kick),
        .wdt_disable(wdt_disable), .rst_pin_n_in(rst_pin_n_in),
        .cmp_out_n(cmp_out_n), .lost_clk(lost_clk), .supply_low(supply_low),
        .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
        .fl_cur_data(fl_cur_data),
        .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_addr(fl_addr),
        .fl_wdata(fl_wdata), .cpu_stall(cpu_stall), .sys_rst_n(sys_rst_n)
    );
    rsg_flash_model rsg_flash_model_inst (
        .core_clk(core_clk), .fl_prog(fl_prog), .fl_erase(fl_erase),
        .fl_addr(fl_addr), .fl_wdata(fl_wdata), .rd_addr(xw_addr),
        .rd_data(fl_cur_data)
    );
    always #2 core_clk = ~core_clk;
    // Regular watchdog service unless a test withholds it
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        wdt_kick <= kick_on && cyc[3:0] == 4'h0;
        if (cyc == 6000) begin
            n_errors = n_errors + 1;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_we <= 1'b1;
        @(posedge core_clk);
        sfr_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_re <= 1'b1;
        @(posedge core_clk);
        sfr_re <= 1'b0;
        #1 chk(sfr_rdata, e);
    endtask
    task automatic prog(logic [7:0] m, logic [15:0] a, logic [7:0] d, logic s);
        int k;
        wr(FK, `RSG_KEY1);
        wr(FK, `RSG_KEY2);
        wr(PS, m);
        @(posedge core_clk);
        xw_addr <= a;
        xw_data <= d;
        xw_short <= s;
        xw_valid <= 1'b1;
        @(posedge core_clk);
        xw_valid <= 1'b0;
        k = 0;
        while (k < 100 && (cpu_stall !== 1'b0 || k < 2)) begin
            @(posedge core_clk);
            #1 k++;
        end
    endtask
    task automatic wait_rst();
        int k;
        k = 0;
        while (sys_rst_n === 1'b1 && k < 300) begin
            @(posedge core_clk);
            #1 k++;
        end
        // Only a supply reset may pull the pin
        chk(16'({rst_pin_o, rst_pin_oe}), 16'(supply_low));
        @(posedge core_clk);
        rst_pin_n_in <= 1'b1;
        supply_low <= 1'b0;
        cmp_out_n <= 1'b1;
        lost_clk <= 1'b0;
        kick_on <= 1'b1;
        supply_on <= 1'b1;
        while (sys_rst_n !== 1'b1 && k < 300) begin
            @(posedge core_clk);
            #1 k++;
        end
        chk(16'(k < 300), 16'h1);
    endtask
    task automatic bad(input logic [15:0] a);
        prog(8'h01, a, 8'h00, 1'b0);
        wait_rst();
        rd(RS, 8'hC0);
        chk(rsg_flash_model_inst.mem[a[12:0]], 8'hFF);
    endtask
    task automatic flt(input logic c, input logic [15:0] a, input logic dn);
        @(posedge core_clk);
        cr_valid <= c;
        br_valid <= !c;
        cr_addr <= a;
        br_addr <= a;
        sec_deny <= dn;
        @(posedge core_clk);
        cr_valid <= 1'b0;
        br_valid <= 1'b0;
        sec_deny <= 1'b0;
        wait_rst();
        rd(RS, 8'hC0);
    endtask
    task automatic ext(input int s, input logic [7:0] e);
        @(posedge core_clk);
        rst_pin_n_in <= s != 0;
        cmp_out_n <= s != 1;
        lost_clk <= s == 2;
        kick_on <= s != 3;
        supply_low <= s == 4;
        wait_rst();
        rd(RS, e);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        rd(RS, 8'h82);
        rd(8'h10, 8'h00);
        $display("reset test done");
        foreach (rows[i]) begin
            prog(8'h01, rows[i].a, rows[i].d, 1'b0);
            chk(rsg_flash_model_inst.mem[rows[i].a], rows[i].e);
            rd(FK, 8'h00);
        end
        $display("program table done");
        prog(8'h03, 16'h0105, 8'h00, 1'b0);
        chk(rsg_flash_model_inst.mem[16'h0100], 8'hFF);
        chk(rsg_flash_model_inst.mem[16'h01FF], 8'hFF);
        chk(rsg_flash_model_inst.mem[16'h0200], 8'h00);
        prog(8'h01, 16'h0080, 8'h3C, 1'b1);
        chk(rsg_flash_model_inst.mem[16'h0080], 8'h3C);
        prog(8'h01, 16'h0120, 8'h00, 1'b1);
        chk(rsg_flash_model_inst.mem[16'h0120], 8'hFF);
        wr(FK, 8'h12);
        rd(FK, 8'h03);
        prog(8'h01, 16'h0101, 8'h00, 1'b0);
        chk(rsg_flash_model_inst.mem[16'h0101], 8'hFF);
        rd(PS, 8'h01);
        $display("erase and key tests done");
        wr(RS, 8'h12);
        wait_rst();
        rd(RS, 8'h90);
        rd(FK, 8'h00);
        wr(RS, 8'h02);
        rd(RS, 8'h90);
        chk(sys_rst_n, 1'b1);
        wr(PS, 8'h01);
        @(posedge core_clk);
        xw_valid <= 1'b1;
        @(posedge core_clk);
        xw_valid <= 1'b0;
        rd(FK, 8'h03);
        // Watchdog switched off here must come back on after the reset
        @(posedge core_clk);
        wdt_disable <= 1'b1;
        @(posedge core_clk);
        wdt_disable <= 1'b0;
        wr(RS, 8'h12);
        wait_rst();
        bad(16'h1E00);
        @(posedge core_clk);
        supply_on <= 1'b0;
        bad(16'h0102);
        flt(1'b1, 16'h1E00, 1'b0);
        flt(1'b0, 16'h1E00, 1'b0);
        flt(1'b1, 16'h0100, 1'b1);
        $display("fault tests done");
        ext(3, 8'h88);
        ext(0, 8'h81);
        wr(RS, 8'h22);
        ext(1, 8'hA0);
        wr(RS, 8'h06);
        ext(2, 8'h84);
        ext(4, 8'h82);
        $display("source tests done");
        wrap_up();
    end
endmodule // tb_rsg_reset_guard
`default_nettype wire
